/* File: ria_consts.vh */
// Purpose: Shared constants for the remote I2C alias remap block
// Assumes: Register indices; byte address on the bus is four times the index
// Notes:   Definitions only
`ifndef RIA_CONSTS_VH
`define RIA_CONSTS_VH

`define RIA_ADDR_W        12
`define RIA_IDX_HI        9
`define RIA_IDX_LO        2
`define RIA_TOP_HI        11
`define RIA_TOP_LO        10
`define RIA_TOP_ZERO      2'h0

// Register indices
`define RIA_IDX_PATH1     8'h59
`define RIA_IDX_PATH2     8'h5A
`define RIA_IDX_SERADDR   8'h5B
`define RIA_IDX_SERALIAS  8'h5C
`define RIA_IDX_NODE0     8'h5D
`define RIA_IDX_NODE1     8'h5E
`define RIA_IDX_NODE2     8'h5F
`define RIA_IDX_NALIAS0   8'h70
`define RIA_IDX_NALIAS1   8'h71
`define RIA_IDX_NALIAS2   8'h72

// Reset values
`define RIA_RST_REG       8'h00
`define RIA_RST_ADDR7     7'h00

// Field positions
`define RIA_OVR_BIT       7
`define RIA_GPIO_HI       1
`define RIA_GPIO_LO       0
`define RIA_HOLD_BIT      0
`define RIA_AUTOACK_BIT   0
`define RIA_ID_HI         7
`define RIA_ID_LO         1
`define RIA_PATH1_MASK    8'h83
`define RIA_ID_MASK       8'hFE

// Bus answers
`define RIA_RESP_OKAY     2'h0
`define RIA_RESP_SLVERR   2'h2

// Decoder slots: slot 0 is the serializer itself, 1..3 are remote nodes
`define RIA_NSLOT         4
`define RIA_NO_ALIAS      7'h00

`endif

/* File: ria_slot_match.v */
// Purpose: One alias decoder slot: compare an address with an alias
// Assumes: All inputs on core_clk, purely combinational
// Notes:   A zero alias never matches
`default_nettype none
`include "ria_consts.vh"

module ria_slot_match (
    // Programmed alias and physical address
    input  wire [6:0] aliasAddr,
    input  wire [6:0] physAddr,
    // Incoming local address
    input  wire [6:0] reqAddr,
    // Decode result
    output wire       hit,
    output wire [6:0] mapAddr
);

    // Zero alias means the decoder is off, so address 0 is never captured
    assign hit     = (aliasAddr != `RIA_NO_ALIAS) && (reqAddr == aliasAddr);
    assign mapAddr = physAddr;

endmodule
`default_nettype wire

/* File: ria_alias_remap.v */
// Purpose: Alias decode and address remap for the control-channel bridge
// Assumes: Forward-channel and I2C request inputs come from logic on core_clk
// Notes:   Registers reached over AXI4-Lite, one 8-bit register per word
//
// How it works
// - Forward channel fills path control two
// - Local path control two writes need override set; path control one writes always land
// - Override stops forward loading, keeps local values
// - Serializer address auto-loads into bits 7:1
// - Hold bit freezes serializer address at written value
// - Compare local address with serializer alias
// - Matching transaction gets physical address substituted
// - Zero alias disables that decoder
// - Auto-ack bit acknowledges writes to serializer
// - Auto-ack ignores lock and remote acknowledge
// - Three node slots hold physical addresses
// - Node alias match remaps to node address
`default_nettype none
`include "ria_consts.vh"

module ria_alias_remap (
    // Clock and reset
    input  wire                     core_clk,
    input  wire                     srst,
    // AXI4-Lite write address
    input  wire [`RIA_ADDR_W-1:0]   s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output wire                     s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]              s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output wire                     s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    // AXI4-Lite read address
    input  wire [`RIA_ADDR_W-1:0]   s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output wire                     s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]              s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready,
    // Configuration received over the forward channel
    input  wire                     fcCfgValid,
    input  wire [7:0]               fcCfgData,
    input  wire [1:0]               fcGpioEn,
    input  wire                     fcSerAddrValid,
    input  wire [6:0]               fcSerAddr,
    input  wire                     fcLocked,
    // Local I2C address phase
    input  wire                     reqValid,
    input  wire [6:0]               reqAddr,
    input  wire                     reqRead,
    // Remapped transaction toward the control channel
    output reg                      fwdValid,
    output reg                      fwdHit,
    output reg  [6:0]               fwdAddr,
    output reg                      fwdRead,
    output reg  [1:0]               fwdSlot,
    output reg                      fwdAutoAck,
    // Acknowledge returned by the remote side and given to the local side
    input  wire                     remAckValid,
    input  wire                     remAck,
    output reg                      localAckValid,
    output reg                      localAck
);

    // Register storage
    reg  [7:0] pathControlOne;
    reg  [7:0] pathControlTwo;
    reg  [7:0] remoteSerAddress;
    reg  [7:0] remoteSerAlias;
    reg  [7:0] nodeAddr  [0:2];
    reg  [7:0] nodeAlias [0:2];

    // Write channel holding state
    reg                     awHeld;
    reg  [`RIA_ADDR_W-1:0]  awAddrHeld;
    reg                     wHeld;
    reg  [7:0]              wDataHeld;
    reg                     wLaneHeld;

    // Last transaction's auto-ack decision, used when the remote answers
    reg                     lastAuto;

    // Derived control bits
    wire forwardCfgOverride = pathControlOne[`RIA_OVR_BIT];
    wire holdRemoteAddress  = remoteSerAddress[`RIA_HOLD_BIT];
    wire remoteWriteAutoack = remoteSerAlias[`RIA_AUTOACK_BIT];

    // Turn a bus address into a register index; top bits are not checked here
    function [7:0] regIndex;
        input [`RIA_ADDR_W-1:0] addr;
        begin
            regIndex = addr[`RIA_IDX_HI:`RIA_IDX_LO];
        end
    endfunction

    // True when the address hits a register; shared by read and write paths
    function isMapped;
        input [`RIA_ADDR_W-1:0] addr;
        reg   [7:0]             idx;
        begin
            idx = addr[`RIA_IDX_HI:`RIA_IDX_LO];
            isMapped = 1'b0;
            if (addr[`RIA_TOP_HI:`RIA_TOP_LO] == `RIA_TOP_ZERO) begin
                case (idx)
                    `RIA_IDX_PATH1, `RIA_IDX_PATH2, `RIA_IDX_SERADDR,
                    `RIA_IDX_SERALIAS, `RIA_IDX_NODE0, `RIA_IDX_NODE1,
                    `RIA_IDX_NODE2, `RIA_IDX_NALIAS0, `RIA_IDX_NALIAS1,
                    `RIA_IDX_NALIAS2: begin
                        isMapped = 1'b1;
                    end
                    default: begin
                        isMapped = 1'b0;
                    end
                endcase
            end
        end
    endfunction

    // Address and data may arrive in either order; each is held once taken
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake  = s_axi_wvalid & s_axi_wready;
    wire haveAw = awHeld | awTake;
    wire haveW  = wHeld | wTake;
    wire doWrite = haveAw & haveW;

    wire [`RIA_ADDR_W-1:0] wrAddr = awHeld ? awAddrHeld : s_axi_awaddr;
    wire [7:0]             wrData = wHeld ? wDataHeld : s_axi_wdata[7:0];
    wire                   wrLane = wHeld ? wLaneHeld : s_axi_wstrb[0];
    wire [7:0]             wrIdx  = regIndex(wrAddr);
    wire                   wrOk   = isMapped(wrAddr);
    wire                   wrEn   = doWrite & wrOk & wrLane;

    // Write handshake bookkeeping and response
    always @(posedge core_clk) begin
        if (srst) begin
            awHeld       <= 1'b0;
            awAddrHeld   <= {`RIA_ADDR_W{1'b0}};
            wHeld        <= 1'b0;
            wDataHeld    <= `RIA_RST_REG;
            wLaneHeld    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RIA_RESP_OKAY;
        end else begin
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrOk ? `RIA_RESP_OKAY : `RIA_RESP_SLVERR;
            end else begin
                if (awTake) begin
                    awHeld     <= 1'b1;
                    awAddrHeld <= s_axi_awaddr;
                end
                if (wTake) begin
                    wHeld     <= 1'b1;
                    wDataHeld <= s_axi_wdata[7:0];
                    wLaneHeld <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Path control registers: forward loading unless software has taken over
    always @(posedge core_clk) begin
        if (srst) begin
            pathControlOne <= `RIA_RST_REG;
            pathControlTwo <= `RIA_RST_REG;
        end else begin
            if (wrEn && wrIdx == `RIA_IDX_PATH1) begin
                pathControlOne <= wrData & `RIA_PATH1_MASK;
            end else if (fcCfgValid && !forwardCfgOverride) begin
                pathControlOne[`RIA_GPIO_HI:`RIA_GPIO_LO] <= fcGpioEn;
            end
            // Local write wins only under override; otherwise forward data rules
            if (wrEn && wrIdx == `RIA_IDX_PATH2 && forwardCfgOverride) begin
                pathControlTwo <= wrData;
            end else if (fcCfgValid && !forwardCfgOverride) begin
                pathControlTwo <= fcCfgData;
            end
        end
    end

    // Serializer address: write always lands, auto-load only when not held
    always @(posedge core_clk) begin
        if (srst) begin
            remoteSerAddress <= `RIA_RST_REG;
        end else if (wrEn && wrIdx == `RIA_IDX_SERADDR) begin
            remoteSerAddress <= wrData;
        end else if (fcSerAddrValid && !holdRemoteAddress) begin
            remoteSerAddress[`RIA_ID_HI:`RIA_ID_LO] <= fcSerAddr;
        end
    end

    // Serializer alias and auto-ack bit
    always @(posedge core_clk) begin
        if (srst) begin
            remoteSerAlias <= `RIA_RST_REG;
        end else if (wrEn && wrIdx == `RIA_IDX_SERALIAS) begin
            remoteSerAlias <= wrData;
        end
    end

    // Node physical addresses and aliases, one pair per slot
    genvar n;
    generate
        for (n = 0; n < 3; n = n + 1) begin : gNode
            always @(posedge core_clk) begin
                if (srst) begin
                    nodeAddr[n]  <= `RIA_RST_REG;
                    nodeAlias[n] <= `RIA_RST_REG;
                end else if (wrEn) begin
                    if (wrIdx == `RIA_IDX_NODE0 + n) begin
                        nodeAddr[n] <= wrData & `RIA_ID_MASK;
                    end
                    if (wrIdx == `RIA_IDX_NALIAS0 + n) begin
                        nodeAlias[n] <= wrData & `RIA_ID_MASK;
                    end
                end
            end
        end
    endgenerate

    // Read data selection
    reg  [7:0] rdByte;
    wire [7:0] rdIdx = regIndex(s_axi_araddr);
    always @* begin
        case (rdIdx)
            `RIA_IDX_PATH1:    rdByte = pathControlOne;
            `RIA_IDX_PATH2:    rdByte = pathControlTwo;
            `RIA_IDX_SERADDR:  rdByte = remoteSerAddress;
            `RIA_IDX_SERALIAS: rdByte = remoteSerAlias;
            `RIA_IDX_NODE0:    rdByte = nodeAddr[0];
            `RIA_IDX_NODE1:    rdByte = nodeAddr[1];
            `RIA_IDX_NODE2:    rdByte = nodeAddr[2];
            `RIA_IDX_NALIAS0:  rdByte = nodeAlias[0];
            `RIA_IDX_NALIAS1:  rdByte = nodeAlias[1];
            `RIA_IDX_NALIAS2:  rdByte = nodeAlias[2];
            default:           rdByte = `RIA_RST_REG;
        endcase
    end

    // Read answer one cycle after the address is taken; unmapped reads zero
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RIA_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (isMapped(s_axi_araddr)) begin
                s_axi_rdata <= {24'h000000, rdByte};
                s_axi_rresp <= `RIA_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RIA_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Decoder slots: slot 0 is the serializer, 1..3 the remote nodes
    wire [6:0] slotAlias [0:`RIA_NSLOT-1];
    wire [6:0] slotPhys  [0:`RIA_NSLOT-1];
    wire [6:0] slotMap   [0:`RIA_NSLOT-1];
    wire [`RIA_NSLOT-1:0] slotHit;

    assign slotAlias[0] = remoteSerAlias[`RIA_ID_HI:`RIA_ID_LO];
    assign slotPhys[0]  = remoteSerAddress[`RIA_ID_HI:`RIA_ID_LO];

    genvar s;
    generate
        for (s = 1; s < `RIA_NSLOT; s = s + 1) begin : gSlotCfg
            assign slotAlias[s] = nodeAlias[s-1][`RIA_ID_HI:`RIA_ID_LO];
            assign slotPhys[s]  = nodeAddr[s-1][`RIA_ID_HI:`RIA_ID_LO];
        end
        for (s = 0; s < `RIA_NSLOT; s = s + 1) begin : gSlot
            ria_slot_match uMatch (
                .aliasAddr (slotAlias[s]),
                .physAddr  (slotPhys[s]),
                .reqAddr   (reqAddr),
                .hit       (slotHit[s]),
                .mapAddr   (slotMap[s])
            );
        end
    endgenerate

    // Fixed priority: serializer first, then nodes in order, so overlap is benign
    reg        next_hit;
    reg [1:0]  next_slot;
    reg [6:0]  next_addr;
    always @* begin
        next_hit  = 1'b0;
        next_slot = 2'h0;
        next_addr = reqAddr;
        if (slotHit[0]) begin
            next_hit  = 1'b1;
            next_slot = 2'h0;
            next_addr = slotMap[0];
        end else if (slotHit[1]) begin
            next_hit  = 1'b1;
            next_slot = 2'h1;
            next_addr = slotMap[1];
        end else if (slotHit[2]) begin
            next_hit  = 1'b1;
            next_slot = 2'h2;
            next_addr = slotMap[2];
        end else if (slotHit[3]) begin
            next_hit  = 1'b1;
            next_slot = 2'h3;
            next_addr = slotMap[3];
        end
    end

    // Auto-ack applies only to writes aimed at the serializer alias
    wire autoNow = slotHit[0] & ~reqRead & remoteWriteAutoack;

    // Registered decode result; a miss is forwarded with fwdHit low and the address unchanged
    always @(posedge core_clk) begin
        if (srst) begin
            fwdValid   <= 1'b0;
            fwdHit     <= 1'b0;
            fwdAddr    <= `RIA_RST_ADDR7;
            fwdRead    <= 1'b0;
            fwdSlot    <= 2'h0;
            fwdAutoAck <= 1'b0;
            lastAuto   <= 1'b0;
        end else begin
            fwdValid <= reqValid;
            if (reqValid) begin
                fwdHit     <= next_hit;
                fwdAddr    <= next_addr;
                fwdRead    <= reqRead;
                fwdSlot    <= next_slot;
                fwdAutoAck <= autoNow;
                lastAuto   <= autoNow;
            end
        end
    end

    // Local acknowledge: forced high under auto-ack, else remote ack when locked
    always @(posedge core_clk) begin
        if (srst) begin
            localAckValid <= 1'b0;
            localAck      <= 1'b0;
        end else begin
            localAckValid <= remAckValid;
            if (remAckValid) begin
                localAck <= lastAuto | (fcLocked & remAck);
            end
        end
    end

endmodule
`default_nettype wire

/* File: ria_alias_remap_assertions.sv */
// Purpose: Port-level checks for the alias remap block
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only top-level ports, attached by bind
`default_nettype none
module ria_alias_remap_assertions (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Decode and acknowledge paths
    input wire logic        fcLocked,
    input wire logic        reqValid,
    input wire logic [6:0]  reqAddr,
    input wire logic        reqRead,
    input wire logic        fwdValid,
    input wire logic        fwdHit,
    input wire logic [6:0]  fwdAddr,
    input wire logic        fwdRead,
    input wire logic [1:0]  fwdSlot,
    input wire logic        fwdAutoAck,
    input wire logic        remAckValid,
    input wire logic        remAck,
    input wire logic        localAckValid,
    input wire logic        localAck
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Request steps, used to build the decode and write-response checks
    sequence sMiss;
        reqValid ##1 (fwdValid && !fwdHit);
    endsequence
    sequence sWrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_FWD_NEXT: assert property (reqValid |=> fwdValid && fwdRead == $past(reqRead))
        else $error("forwarded request missing or late");
    AST_MISS_KEEP: assert property (sMiss |-> fwdAddr == $past(reqAddr))
        else $error("address changed on a miss");
    AST_AUTO_SER: assert property (fwdValid && fwdAutoAck |-> fwdHit && !fwdRead && fwdSlot == 2'h0)
        else $error("auto-ack on a non-serializer write");
    AST_ACK_NEXT: assert property (remAckValid |=> localAckValid)
        else $error("local acknowledge missing");
    // Lock and remote answer cannot veto a forced acknowledge
    AST_ACK_VALUE: assert property (remAckValid && !reqValid |=>
            localAck == ($past(fwdAutoAck) | ($past(fcLocked) & $past(remAck))))
        else $error("local acknowledge value wrong");
    AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    AST_WR_RESP: assert property (sWrBoth |=> s_axi_bvalid)
        else $error("write response late");
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
endmodule
bind ria_alias_remap ria_alias_remap_assertions ria_alias_remap_assertions_i (
    .core_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fcLocked, .reqValid,
    .reqAddr, .reqRead, .fwdValid, .fwdHit, .fwdAddr, .fwdRead, .fwdSlot, .fwdAutoAck,
    .remAckValid, .remAck, .localAckValid, .localAck);
`default_nettype wire

/* File: ria_far_model.sv */
// Purpose: Far-side model: remote serializer and its forward channel
// Assumes: Bench commands change just after a rising edge
// Notes:   Answers each forwarded request fast or a few cycles late
`default_nettype none
module ria_far_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Bench commands
    input  wire logic       cfgGo,
    input  wire logic       addrGo,
    input  wire logic [7:0] cfgByte,
    input  wire logic       ackBit,
    input  wire logic       slow,
    // Bridge side
    input  wire logic       fwdValid,
    output logic            fcCfgValid,
    output logic [7:0]      fcCfgData,
    output logic [1:0]      fcGpioEn,
    output logic            fcSerAddrValid,
    output logic [6:0]      fcSerAddr,
    output logic            remAckValid,
    output logic            remAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pend;
    logic [1:0] cnt;
    // Idle lines toggle so a stale value can never pass for a real load
    always @(posedge core_clk) begin
        fcCfgValid <= cfgGo;
        fcSerAddrValid <= addrGo;
        fcCfgData <= cfgGo ? cfgByte : ~fcCfgData;
        fcGpioEn <= cfgGo ? cfgByte[1:0] : ~fcGpioEn;
        fcSerAddr <= addrGo ? cfgByte[6:0] : ~fcSerAddr;
        remAckValid <= 1'b0;
        remAck <= ~remAck;
        if (srst) begin
            {fcCfgData, fcGpioEn, fcSerAddr, remAck, pend, cnt} <= 21'h0;
        end else if (fwdValid) begin
            pend <= 1'b1;
            cnt <= slow ? 2'h3 : 2'h0;
        end else if (pend && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            remAckValid <= 1'b1;
            remAck <= ackBit;
        end
    end
endmodule
`default_nettype wire

/* File: ria_alias_remap_tb.sv */
// Purpose: Self-checking bench for the alias remap block
// Assumes: Bus byte address is four times the register index
// Notes:   Drivers queue expected results; a monitor compares in order
`default_nettype none
`include "ria_consts.vh"
module ria_alias_remap_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, srst, fcLocked, reqValid, reqRead, cfgGo, addrGo, ackBit, slow;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, fwdSlot;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        fcCfgValid, fcSerAddrValid, fwdValid, fwdHit, fwdRead, fwdAutoAck;
    logic        remAckValid, remAck, localAckValid, localAck;
    logic [7:0]  fcCfgData, cfgByte;
    logic [6:0]  fcSerAddr, reqAddr, fwdAddr;
    logic [6:0]  p [3];
    logic [1:0]  fcGpioEn;
    logic [33:0] qR[$], qB[$], qF[$], qA[$];
    int          n_fail, checks;
    ria_alias_remap ria_alias_remap_i (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .fcCfgValid, .fcCfgData, .fcGpioEn, .fcSerAddrValid, .fcSerAddr, .fcLocked,
        .reqValid, .reqAddr, .reqRead, .fwdValid, .fwdHit, .fwdAddr, .fwdRead, .fwdSlot,
        .fwdAutoAck, .remAckValid, .remAck, .localAckValid, .localAck);
    ria_far_model ria_far_model_i (.core_clk, .srst, .cfgGo, .addrGo, .cfgByte, .ackBit,
        .slow, .fwdValid, .fcCfgValid, .fcCfgData, .fcGpioEn, .fcSerAddrValid, .fcSerAddr,
        .remAckValid, .remAck);
    // Free-running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // A wait that runs out counts as a mismatch and ends the run
    task automatic limit(input int n);
        if (n >= 40) begin
            n_fail++;
            $display("unexpected at %0t: no answer", $time);
            report_and_stop();
        end
    endtask
    // Bus write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        qB.push_back({32'h0, er});
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        limit(n);
    endtask
    task automatic rd(input logic [7:0] i, input logic [33:0] e);
        int n;
        n = 0;
        qR.push_back(e);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        limit(n);
    endtask
    // Local request; e is {hit, address, slot, auto-ack}; lock and answer are random
    task automatic rq(input logic [6:0] a, input logic isRd, input logic [10:0] e);
        int n;
        logic lk, ak, sl;
        n = 0;
        {lk, ak, sl} = 3'($urandom);
        qF.push_back({23'h0, e});
        qA.push_back({33'h0, e[0] | (lk & ak)});
        fcLocked <= lk;
        ackBit <= ak;
        slow <= sl;
        reqAddr <= a;
        reqRead <= isRd;
        reqValid <= 1'b1;
        @(posedge core_clk);
        reqValid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!localAckValid && n < 40);
        limit(n);
    endtask
    // Forward-channel load through the model: one cycle there, one to land
    task automatic fc(input logic isAddr, input logic [7:0] v);
        cfgByte <= v;
        cfgGo <= !isAddr;
        addrGo <= isAddr;
        @(posedge core_clk);
        cfgGo <= 1'b0;
        addrGo <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // Monitor: the oldest note of each stream against what appears
    always @(posedge core_clk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, qR.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, qB.pop_front());
        if (fwdValid) check({fwdHit, fwdAddr, fwdHit ? fwdSlot : 2'h0, fwdAutoAck}, qF.pop_front());
        if (localAckValid) check({33'h0, localAck}, qA.pop_front());
    end
    // Main sequence
    initial begin
        srst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cfgByte, reqAddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {fcLocked, reqValid, reqRead, cfgGo, addrGo, ackBit, slow} = '0;
        void'($urandom(32'hACEC));
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int i = 8'h59; i <= 8'h5F; i++) rd(8'(i), 34'h0);
        rq(7'h00, 1'b0, 11'h000);
        wr(8'h40, 8'hFF, `RIA_RESP_SLVERR);
        rd(8'h40, {`RIA_RESP_SLVERR, 32'h0});
        fc(1'b0, 8'hA5);
        rd(`RIA_IDX_PATH2, 34'hA5);
        rd(`RIA_IDX_PATH1, 34'h01);
        wr(`RIA_IDX_PATH2, 8'h3C, `RIA_RESP_OKAY);
        rd(`RIA_IDX_PATH2, 34'hA5);
        wr(`RIA_IDX_PATH1, 8'h80, `RIA_RESP_OKAY);
        fc(1'b0, 8'h5A);
        rd(`RIA_IDX_PATH2, 34'hA5);
        rd(`RIA_IDX_PATH1, 34'h80);
        wr(`RIA_IDX_PATH2, 8'h3C, `RIA_RESP_OKAY);
        rd(`RIA_IDX_PATH2, 34'h3C);
        fc(1'b1, 8'h2B);
        rd(`RIA_IDX_SERADDR, 34'h56);
        wr(`RIA_IDX_SERADDR, 8'h23, `RIA_RESP_OKAY);
        fc(1'b1, 8'h33);
        rd(`RIA_IDX_SERADDR, 34'h23);
        wr(`RIA_IDX_SERALIAS, 8'hA1, `RIA_RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            p[k] = 7'($urandom);
            wr(`RIA_IDX_NODE0 + 8'(k), {p[k], 1'b1}, `RIA_RESP_OKAY);
            rd(`RIA_IDX_NODE0 + 8'(k), {26'h0, p[k], 1'b0});
            wr(`RIA_IDX_NALIAS0 + 8'(k), {7'h41 + 7'(k), 1'b0}, `RIA_RESP_OKAY);
            rq(7'h41 + 7'(k), 1'(k), {1'b1, p[k], 2'(k + 1), 1'b0});
        end
        rq(7'h50, 1'b0, {1'b1, 7'h11, 2'h0, 1'b1});
        rq(7'h50, 1'b1, {1'b1, 7'h11, 2'h0, 1'b0});
        rq(7'h22, 1'b0, {1'b0, 7'h22, 2'h0, 1'b0});
        wr(`RIA_IDX_SERALIAS, 8'h01, `RIA_RESP_OKAY);
        rq(7'h00, 1'b0, 11'h000);
        report_and_stop();
    end
endmodule
`default_nettype wire
